// File: switchover_defines.svh
/*
 * constants for the backup switchover signaling block: timing counts,
 * control and status byte layout, reset values.
 * assumes a 40 MHz ref_clk; every cycle count below derives from it.
 */
`ifndef SWITCHOVER_DEFINES_SVH
`define SWITCHOVER_DEFINES_SVH


// ----------------------------------------
// timebase
// ----------------------------------------
`define CLK_MHZ 40
`define CLK_KHZ 40000
`define TRIG_PULSE_MS 200
`define TRIG_CYC (`TRIG_PULSE_MS * `CLK_KHZ)
`define TRIG_CNT_W 24
`define GATE_PRE_US 62
`define GATE_PRE_CYC (`GATE_PRE_US * `CLK_MHZ)
`define GATE_CNT_W 12
`define TAP_PD_US 10
`define TAP_PD_CYC (`TAP_PD_US * `CLK_MHZ)
`define TAP_CNT_W 9
`define SPIKE_NS 50
`define SPIKE_CYC ((`SPIKE_NS * `CLK_MHZ) / 1000)

// ----------------------------------------
// two-wire port and control byte
// ----------------------------------------
`define TARGET_ADDR 7'h2a
`define CTRL_CHG_BIT 0
`define CTRL_HC_BIT 1
`define CTRL_TAP_BIT 2
`define CTRL_RESET 8'h01
`define PIN_BOOST_RUN 0
`define PIN_PRIMARY_LOST 1
`define PIN_BOOST_REG 2
`define PIN_THERMAL 3
`define PIN_CHG_DIS 4

`endif

// File: switchover_pkg.sv
/*
 * types shared by the switchover block: state enums and state structs.
 * assumes switchover_defines.svh is available on the include path.
 */
`include "switchover_defines.svh"

package switchover_pkg;
    typedef enum logic [1:0] {HC_OFF, HC_PREDRIVE, HC_RUN} hc_state_t;
    typedef enum logic [2:0] {I_IDLE, I_ADDR, I_ACKA, I_WR, I_ACKD, I_RD, I_MACK} port_state_t;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] q;
        logic [1:0][1:0] cnt;
    } filt_state_t;

    typedef struct packed {
        logic [4:0] p1;
        logic [4:0] p2;
        logic scl_d;
        logic sda_d;
        port_state_t pst;
        logic [3:0] bcnt;
        logic [7:0] sh;
        logic sda_oe;
        logic [7:0] ctrl;
        logic boost_prev;
        logic trig;
        logic [`TRIG_CNT_W-1:0] trig_cnt;
        hc_state_t hst;
        logic [`GATE_CNT_W-1:0] gate_cnt;
        logic gate_oe;
        logic sink_en;
        logic tap_sw;
        logic tap_pd;
        logic [`TAP_CNT_W-1:0] tap_cnt;
        logic chg_en;
        logic stat_oe;
        logic avi_en;
        logic avi_pd;
    } core_state_t;
endpackage

// File: twowire_if.sv
/*
 * carrier for the filtered two-wire port lines between the input filter
 * and the switchover core; both sides run on ref_clk.
 */
`timescale 1ns/1ps

interface twowire_if;
    logic scl;
    logic sda;
    modport filt (output scl, output sda);
    modport core (input scl, input sda);
endinterface

// File: twowire_filter.sv
/*
 * synchroniser and spike filter for the two-wire port inputs.
 * assumes raw pins asynchronous to ref_clk; idle bus level is high.
 */
`timescale 1ns/1ps
`include "switchover_defines.svh"

module twowire_filter (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_in,
    twowire_if.filt tw
);
    switchover_pkg::filt_state_t st_r;
    switchover_pkg::filt_state_t st_nxt;

    // ----------------------------------------
    // filter: a new level must persist past the spike width
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = {sda_in, scl_in};
        st_nxt.s2 = st_r.s1;
        for (int i = 0; i < 2; i++) begin
            if (st_r.s2[i] != st_r.q[i]) begin
                if (st_r.cnt[i] == 2'(`SPIKE_CYC)) begin
                    st_nxt.q[i] = st_r.s2[i];
                    st_nxt.cnt[i] = 2'h0;
                end else begin
                    st_nxt.cnt[i] = st_r.cnt[i] + 2'h1;
                end
            end else begin
                st_nxt.cnt[i] = 2'h0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_r <= '{s1: 2'h3, s2: 2'h3, q: 2'h3, cnt: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tw.scl = st_r.q[0];
    assign tw.sda = st_r.q[1];
endmodule

// File: switchover_core.sv
/*
 * backup switchover signaling: trigger pulse, boost status pin, charger
 * gating, health-check gate and tap sequencing, two-wire target port.
 * assumes analog status levels arrive asynchronously on pins and that
 * the analog loops themselves live outside this block.
 */
`timescale 1ns/1ps
`include "switchover_defines.svh"

module switchover_core #(
    parameter int unsigned TRIG_CYCLES = `TRIG_CYC
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic boost_running,
    input wire logic primary_lost,
    input wire logic boost_regulating,
    input wire logic thermal_shutdown,
    input wire logic charger_disable_in,
    output logic backup_trigger_out,
    output logic boost_active_n_out,
    output logic boost_active_n_oe,
    output logic charger_enable,
    output logic sink_gate_drive_out,
    output logic sink_gate_drive_oe,
    output logic sink_enable,
    output logic battery_voltage_tap_switch,
    output logic battery_voltage_tap_pulldown,
    output logic sink_current_tap_enable,
    output logic sink_current_tap_pulldown,
    output logic [7:0] ctrl_byte
);
    localparam logic [`TRIG_CNT_W-1:0] TRIG_LAST = `TRIG_CNT_W'(TRIG_CYCLES - 1);
    localparam logic [`GATE_CNT_W-1:0] GATE_LAST = `GATE_CNT_W'(`GATE_PRE_CYC - 1);
    // the first count shares the edge that raises the pull-down, so the lead ends one count later
    localparam logic [`TAP_CNT_W-1:0] TAP_LAST = `TAP_CNT_W'(`TAP_PD_CYC);

    twowire_if tw ();

    switchover_pkg::core_state_t st_r;
    switchover_pkg::core_state_t st_nxt;

    logic permit;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic [7:0] status_byte;

    twowire_filter u_filter (
        .ref_clk(ref_clk),
        .srst(srst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .tw(tw.filt)
    );

    // ----------------------------------------
    // derived conditions
    // ----------------------------------------
    // only the second sync stage is ever read
    assign permit = st_r.ctrl[`CTRL_HC_BIT] & ~st_r.p2[`PIN_BOOST_REG]
        & ~st_r.p2[`PIN_THERMAL];
    assign scl_rise = tw.scl & ~st_r.scl_d;
    assign scl_fall = ~tw.scl & st_r.scl_d;
    assign start_cond = tw.scl & st_r.scl_d & st_r.sda_d & ~tw.sda;
    assign stop_cond = tw.scl & st_r.scl_d & ~st_r.sda_d & tw.sda;
    assign status_byte = {st_r.p2, st_r.hst == switchover_pkg::HC_RUN, st_r.tap_sw, st_r.trig};

    always_comb begin
        st_nxt = st_r;
        st_nxt.p1 = {charger_disable_in, thermal_shutdown, boost_regulating,
            primary_lost, boost_running};
        st_nxt.p2 = st_r.p1;
        st_nxt.scl_d = tw.scl;
        st_nxt.sda_d = tw.sda;

        // ----------------------------------------
        // two-wire target: one control byte written, status read back
        // ----------------------------------------
        if (start_cond) begin
            st_nxt.pst = switchover_pkg::I_ADDR;
            st_nxt.bcnt = 4'h0;
            st_nxt.sda_oe = 1'b0;
        end else if (stop_cond) begin
            st_nxt.pst = switchover_pkg::I_IDLE;
            st_nxt.sda_oe = 1'b0;
        end else if (scl_rise) begin
            case (st_r.pst)
                switchover_pkg::I_ADDR, switchover_pkg::I_WR: begin
                    st_nxt.sh = {st_r.sh[6:0], tw.sda};
                    st_nxt.bcnt = st_r.bcnt + 4'h1;
                end
                switchover_pkg::I_RD: begin
                    st_nxt.sh = {st_r.sh[6:0], 1'b0};
                    st_nxt.bcnt = st_r.bcnt + 4'h1;
                end
                switchover_pkg::I_MACK: begin
                    // a nack from the controller ends the read
                    if (tw.sda) begin
                        st_nxt.pst = switchover_pkg::I_IDLE;
                    end else begin
                        st_nxt.pst = switchover_pkg::I_RD;
                        st_nxt.bcnt = 4'h0;
                        st_nxt.sh = status_byte;
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (st_r.pst)
                switchover_pkg::I_ADDR: begin
                    if (st_r.bcnt == 4'h8) begin
                        if (st_r.sh[7:1] == `TARGET_ADDR) begin
                            st_nxt.pst = switchover_pkg::I_ACKA;
                            st_nxt.sda_oe = 1'b1;
                        end else begin
                            st_nxt.pst = switchover_pkg::I_IDLE;
                        end
                    end
                end
                switchover_pkg::I_ACKA: begin
                    st_nxt.bcnt = 4'h0;
                    if (st_r.sh[0]) begin
                        st_nxt.pst = switchover_pkg::I_RD;
                        st_nxt.sh = status_byte;
                        st_nxt.sda_oe = ~status_byte[7];
                    end else begin
                        st_nxt.pst = switchover_pkg::I_WR;
                        st_nxt.sda_oe = 1'b0;
                    end
                end
                switchover_pkg::I_WR: begin
                    if (st_r.bcnt == 4'h8) begin
                        st_nxt.ctrl = st_r.sh;
                        st_nxt.pst = switchover_pkg::I_ACKD;
                        st_nxt.sda_oe = 1'b1;
                    end
                end
                switchover_pkg::I_ACKD: begin
                    st_nxt.pst = switchover_pkg::I_WR;
                    st_nxt.bcnt = 4'h0;
                    st_nxt.sda_oe = 1'b0;
                end
                switchover_pkg::I_RD: begin
                    if (st_r.bcnt == 4'h8) begin
                        st_nxt.pst = switchover_pkg::I_MACK;
                        st_nxt.sda_oe = 1'b0;
                    end else begin
                        st_nxt.sda_oe = ~st_r.sh[7];
                    end
                end
                default: begin
                end
            endcase
        end

        // ----------------------------------------
        // switchover trigger and status pin
        // ----------------------------------------
        st_nxt.boost_prev = st_r.p2[`PIN_BOOST_RUN];
        if (st_r.p2[`PIN_BOOST_RUN] & ~st_r.boost_prev) begin
            st_nxt.trig = 1'b1;
            st_nxt.trig_cnt = '0;
        end else if (st_r.trig) begin
            if (st_r.trig_cnt == TRIG_LAST) begin
                st_nxt.trig = 1'b0;
            end else begin
                st_nxt.trig_cnt = st_r.trig_cnt + 1'b1;
            end
        end
        st_nxt.stat_oe = st_r.p2[`PIN_BOOST_RUN] & st_r.p2[`PIN_PRIMARY_LOST];

        // ----------------------------------------
        // charger gating: the pin wins over the register
        // ----------------------------------------
        st_nxt.chg_en = st_r.ctrl[`CTRL_CHG_BIT] & ~st_r.p2[`PIN_CHG_DIS];

        // ----------------------------------------
        // health-check gate sequencing
        // ----------------------------------------
        if (!permit) begin
            st_nxt.hst = switchover_pkg::HC_OFF;
            st_nxt.gate_oe = 1'b0;
            st_nxt.sink_en = 1'b0;
        end else begin
            case (st_r.hst)
                switchover_pkg::HC_OFF: begin
                    st_nxt.hst = switchover_pkg::HC_PREDRIVE;
                    st_nxt.gate_oe = 1'b1;
                    st_nxt.gate_cnt = '0;
                end
                switchover_pkg::HC_PREDRIVE: begin
                    if (st_r.gate_cnt == GATE_LAST) begin
                        st_nxt.hst = switchover_pkg::HC_RUN;
                        st_nxt.sink_en = 1'b1;
                    end else begin
                        st_nxt.gate_cnt = st_r.gate_cnt + 1'b1;
                    end
                end
                switchover_pkg::HC_RUN: begin
                    st_nxt.sink_en = 1'b1;
                end
                default: begin
                    st_nxt.hst = switchover_pkg::HC_OFF;
                end
            endcase
        end
        // the current tap is live only while the sink runs
        st_nxt.avi_en = st_nxt.hst == switchover_pkg::HC_RUN;
        st_nxt.avi_pd = st_nxt.hst != switchover_pkg::HC_RUN;

        // ----------------------------------------
        // battery voltage tap: pull-down leads the switch opening
        // ----------------------------------------
        if (st_r.ctrl[`CTRL_TAP_BIT]) begin
            st_nxt.tap_sw = 1'b1;
            st_nxt.tap_pd = 1'b0;
            st_nxt.tap_cnt = '0;
        end else if (st_r.tap_sw) begin
            st_nxt.tap_pd = 1'b1;
            if (st_r.tap_cnt == TAP_LAST) begin
                st_nxt.tap_sw = 1'b0;
            end else begin
                st_nxt.tap_cnt = st_r.tap_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_r <= '0;
            st_r.p1 <= 5'h00;
            st_r.scl_d <= 1'b1;
            st_r.sda_d <= 1'b1;
            st_r.pst <= switchover_pkg::I_IDLE;
            st_r.ctrl <= `CTRL_RESET;
            st_r.hst <= switchover_pkg::HC_OFF;
            st_r.tap_pd <= 1'b1;
            st_r.avi_pd <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // outputs, all straight from the state register
    // ----------------------------------------
    // open-drain pins only ever drive low; the data lines stay zero
    assign sda_out = st_r.tap_pd & 1'b0;
    assign sda_oe = st_r.sda_oe;
    assign backup_trigger_out = st_r.trig;
    assign boost_active_n_out = st_r.stat_oe & 1'b0;
    assign boost_active_n_oe = st_r.stat_oe;
    assign charger_enable = st_r.chg_en;
    // the gate is driven up to the charger output node, never pulled low
    assign sink_gate_drive_out = st_r.gate_oe;
    assign sink_gate_drive_oe = st_r.gate_oe;
    assign sink_enable = st_r.sink_en;
    assign battery_voltage_tap_switch = st_r.tap_sw;
    assign battery_voltage_tap_pulldown = st_r.tap_pd;
    assign sink_current_tap_enable = st_r.avi_en;
    assign sink_current_tap_pulldown = st_r.avi_pd;
    assign ctrl_byte = st_r.ctrl;
endmodule

// File: switchover_core_chk.sv
/* concurrent checks on the switchover core ports.
   assumes one ref_clk domain with synchronous srst and pins driven off the edge. */
`timescale 1ns/1ps

module switchover_core_chk #(
    parameter int unsigned TRIG_CYCLES = 8000000
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic sda_out,
    input wire logic boost_running,
    input wire logic primary_lost,
    input wire logic thermal_shutdown,
    input wire logic charger_disable_in,
    input wire logic backup_trigger_out,
    input wire logic boost_active_n_out,
    input wire logic boost_active_n_oe,
    input wire logic charger_enable,
    input wire logic sink_gate_drive_out,
    input wire logic sink_gate_drive_oe,
    input wire logic sink_enable,
    input wire logic battery_voltage_tap_switch,
    input wire logic battery_voltage_tap_pulldown,
    input wire logic sink_current_tap_enable,
    input wire logic sink_current_tap_pulldown,
    input wire logic [7:0] ctrl_byte
);
    // ----------------------------------------
    // helper counters
    // ----------------------------------------
    logic [31:0] hi_cnt_r;
    logic [31:0] pre_cnt_r;
    logic [31:0] pd_cnt_r;

    // counters stand in for long repetitions, which the tools unroll badly
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            hi_cnt_r <= '0;
            pre_cnt_r <= '0;
            pd_cnt_r <= '0;
        end else begin
            hi_cnt_r <= backup_trigger_out ? hi_cnt_r + 32'h1 : '0;
            pre_cnt_r <= (sink_gate_drive_oe && !sink_enable) ? pre_cnt_r + 32'h1 : '0;
            pd_cnt_r <= (battery_voltage_tap_pulldown && battery_voltage_tap_switch) ? pd_cnt_r + 32'h1 : '0;
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    a_trig_start: assert property ($rose(boost_running) |-> ##[3:5] backup_trigger_out)
        else $error("trigger did not follow boost start");
    a_trig_width: assert property ($fell(backup_trigger_out) |-> hi_cnt_r >= TRIG_CYCLES)
        else $error("trigger pulse too short");
    a_status_on: assert property ((boost_running && primary_lost) [*4] |-> boost_active_n_oe)
        else $error("status pin not pulled low");
    a_status_off: assert property (!(boost_running && primary_lost) [*4] |-> !boost_active_n_oe)
        else $error("status pin pulled without cause");
    a_od_low: assert property (!sda_out && !boost_active_n_out)
        else $error("open drain level not low");
    a_charger_block: assert property (charger_disable_in [*4] |-> !charger_enable)
        else $error("charger on while disable pin high");
    a_gate_permit: assert property (!ctrl_byte[1] |=> !sink_gate_drive_oe)
        else $error("gate driven without enable bit");
    a_thermal_block: assert property (thermal_shutdown [*5] |-> !sink_gate_drive_oe && !sink_enable)
        else $error("health check active in shutdown");
    a_sink_gated: assert property (sink_enable |-> sink_gate_drive_oe && sink_gate_drive_out)
        else $error("sink on without gate drive");
    a_predrive_len: assert property ($rose(sink_enable) |-> pre_cnt_r >= 2478 && pre_cnt_r <= 2482)
        else $error("gate pre-drive length wrong");
    a_avi_pulldown: assert property (sink_current_tap_pulldown == !sink_current_tap_enable
        && sink_current_tap_enable == sink_enable)
        else $error("current tap pull-down wrong");
    a_tap_lead: assert property ($fell(battery_voltage_tap_switch) |-> battery_voltage_tap_pulldown
        && pd_cnt_r >= 398 && pd_cnt_r <= 402)
        else $error("tap pull-down lead wrong");
    a_tap_open_pd: assert property (!battery_voltage_tap_switch |-> battery_voltage_tap_pulldown)
        else $error("open tap without pull-down");

    c_sink_run: cover property ($rose(sink_enable));
    c_tap_open: cover property ($fell(battery_voltage_tap_switch));
    c_trig_end: cover property ($fell(backup_trigger_out));
endmodule

bind switchover_core switchover_core_chk #(.TRIG_CYCLES(TRIG_CYCLES)) u_switchover_core_chk (
    .ref_clk(ref_clk), .srst(srst), .sda_out(sda_out), .boost_running(boost_running),
    .primary_lost(primary_lost), .thermal_shutdown(thermal_shutdown), .charger_disable_in(charger_disable_in),
    .backup_trigger_out(backup_trigger_out), .boost_active_n_out(boost_active_n_out),
    .boost_active_n_oe(boost_active_n_oe), .charger_enable(charger_enable),
    .sink_gate_drive_out(sink_gate_drive_out), .sink_gate_drive_oe(sink_gate_drive_oe), .sink_enable(sink_enable),
    .battery_voltage_tap_switch(battery_voltage_tap_switch),
    .battery_voltage_tap_pulldown(battery_voltage_tap_pulldown),
    .sink_current_tap_enable(sink_current_tap_enable), .sink_current_tap_pulldown(sink_current_tap_pulldown),
    .ctrl_byte(ctrl_byte));

// File: twowire_host.sv
/* host controller model for the two-wire port, bit-banged on ref_clk steps.
   assumes the bench resolves the data wire with a pull-up from sda_low and the target's enable. */
`timescale 1ns/1ps

module twowire_host (
    input wire logic ref_clk,
    output logic scl,
    output logic sda_low,
    input wire logic sda_line
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask

    task automatic start();
        sda_low = 1'b1;
        step(30);
        scl = 1'b0;
    endtask

    // bus-free gap after stop keeps well above the minimum
    task automatic stop();
        step(10);
        sda_low = 1'b1;
        step(30);
        scl = 1'b1;
        step(30);
        sda_low = 1'b0;
        step(60);
    endtask

    // nine bits msb first; a one releases the line so the target may answer
    task automatic byte9(input logic [8:0] v, input logic spike, output logic [8:0] got);
        for (int i = 8; i >= 0; i--) begin
            step(10);
            sda_low = !v[i];
            step(50);
            scl = 1'b1;
            step(10);
            if (spike && i == 5) begin
                scl = 1'b0;
                step(2);
                scl = 1'b1;
            end
            step(10);
            got[i] = sda_line;
            step(20);
            scl = 1'b0;
        end
    endtask
endmodule

// File: backup_switchover_signaling_tb.sv
/* self-checking bench for the switchover core.
   assumes the checker is bound to the core and the host model drives the port. */
`timescale 1ns/1ps

module backup_switchover_signaling_tb;
    localparam int unsigned TRIG_N = 100;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic boost_running = 1'b0;
    logic primary_lost = 1'b0;
    logic boost_regulating = 1'b0;
    logic thermal_shutdown = 1'b0;
    logic charger_disable_in = 1'b0;
    logic scl, sda_low, sda_line, sda_out, sda_oe, backup_trigger_out, boost_active_n_out, boost_active_n_oe;
    logic charger_enable, sink_gate_drive_out, sink_gate_drive_oe, sink_enable, battery_voltage_tap_switch;
    logic battery_voltage_tap_pulldown, sink_current_tap_enable, sink_current_tap_pulldown;
    logic [7:0] ctrl_byte;
    logic [8:0] ack9, dat9;
    int errors = 0;
    int comparisons = 0;
    int n;
    // {disable pin, boost, primary lost} then {charger enable, status pull}
    logic [4:0] rows [5] = '{5'b000_10, 5'b100_00, 5'b011_11, 5'b010_10, 5'b001_10};

    always #12.5 ref_clk = ~ref_clk;
    assign sda_line = sda_oe ? sda_out : !sda_low;

    switchover_core #(.TRIG_CYCLES(TRIG_N)) u_switchover_core (
        .ref_clk(ref_clk), .srst(srst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .boost_running(boost_running), .primary_lost(primary_lost), .boost_regulating(boost_regulating),
        .thermal_shutdown(thermal_shutdown), .charger_disable_in(charger_disable_in),
        .backup_trigger_out(backup_trigger_out), .boost_active_n_out(boost_active_n_out),
        .boost_active_n_oe(boost_active_n_oe), .charger_enable(charger_enable),
        .sink_gate_drive_out(sink_gate_drive_out), .sink_gate_drive_oe(sink_gate_drive_oe),
        .sink_enable(sink_enable), .battery_voltage_tap_switch(battery_voltage_tap_switch),
        .battery_voltage_tap_pulldown(battery_voltage_tap_pulldown),
        .sink_current_tap_enable(sink_current_tap_enable), .sink_current_tap_pulldown(sink_current_tap_pulldown),
        .ctrl_byte(ctrl_byte));
    twowire_host u_twowire_host (.ref_clk(ref_clk), .scl(scl), .sda_low(sda_low), .sda_line(sda_line));

    task automatic tick();
        @(posedge ref_clk);
        #2;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic xact(input logic [7:0] adr, input logic [7:0] dat, input logic spike);
        u_twowire_host.start();
        u_twowire_host.byte9({adr, 1'b1}, 1'b0, ack9);
        u_twowire_host.byte9({dat, 1'b1}, spike, dat9);
        u_twowire_host.stop();
    endtask

    task automatic print_verdict();
        if (errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge ref_clk);
        errors++;
        print_verdict();
    end

    initial begin
        repeat (5) tick();
        srst = 1'b0;
        repeat (5) tick();
        for (int i = 0; i < 5; i++) begin
            {charger_disable_in, boost_running, primary_lost} = rows[i][4:2];
            repeat (5) tick();
            check({charger_enable, boost_active_n_oe}, rows[i][1:0]);
        end
        // the row table already fired a pulse; let it run out so the wait below cannot take it for the new one
        n = 0;
        while (backup_trigger_out === 1'b1 && n < 300) begin
            tick();
            n++;
        end
        boost_running = 1'b1;
        n = 0;
        while (backup_trigger_out !== 1'b1 && n < 10) begin
            tick();
            n++;
        end
        n = 0;
        while (backup_trigger_out === 1'b1 && n < 300) begin
            tick();
            n++;
        end
        check(n, TRIG_N);
        // spike inside a data bit must not shift the byte
        xact(8'h54, 8'h06, 1'b1);
        check({ack9[0], dat9[0]}, 2'b00);
        check({ctrl_byte, charger_enable, battery_voltage_tap_switch, battery_voltage_tap_pulldown,
               sink_gate_drive_oe, sink_gate_drive_out, sink_enable}, {8'h06, 6'b010110});
        n = 0;
        while (sink_enable !== 1'b1 && n < 3000) begin
            tick();
            n++;
        end
        check({sink_enable, sink_current_tap_enable, sink_current_tap_pulldown}, 3'b110);
        xact(8'h55, 8'hff, 1'b0);
        check({ack9[0], dat9[8:1]}, 9'h01e);
        xact(8'h56, 8'h00, 1'b0);
        check({ack9[0], ctrl_byte}, 9'h106);
        for (int i = 0; i < 2; i++) begin
            {boost_regulating, thermal_shutdown} = (i == 0) ? 2'b01 : 2'b10;
            repeat (5) tick();
            check({sink_gate_drive_oe, sink_enable, sink_current_tap_pulldown}, 3'b001);
            {boost_regulating, thermal_shutdown} = 2'b00;
            repeat (5) tick();
            check({sink_gate_drive_oe, sink_enable}, 2'b10);
        end
        xact(8'h54, 8'h00, 1'b0);
        check({battery_voltage_tap_switch, battery_voltage_tap_pulldown, sink_gate_drive_oe}, 3'b110);
        n = 0;
        while (battery_voltage_tap_switch !== 1'b0 && n < 500) begin
            tick();
            n++;
        end
        check({battery_voltage_tap_switch, battery_voltage_tap_pulldown}, 2'b01);
        // second reset in mid-run restores defaults
        srst = 1'b1;
        repeat (2) tick();
        check({ctrl_byte, backup_trigger_out, battery_voltage_tap_switch, battery_voltage_tap_pulldown,
               sink_current_tap_pulldown, sink_gate_drive_oe, boost_active_n_oe}, {8'h01, 6'b001100});
        srst = 1'b0;
        repeat (4) tick();
        check(charger_enable, 1'b1);
        print_verdict();
    end
endmodule
